// ===== logic/commutation_pkg.sv
// constants, configuration layout and hall helpers for the axis block
package commutation_pkg;

    localparam int NUM_OUT        = 8;
    localparam int CLK_PERIOD_NS  = 10;
    localparam int MS_NS          = 1000000;
    localparam int MS_CYCLES      = MS_NS / CLK_PERIOD_NS;
    localparam int ZERO_SETTLE_MS = 500;
    localparam int TICK_W         = 24;
    localparam int DIV_STEPS      = 48;
    localparam int CFG_W          = 80;

    // one electrical turn is 2^32 angle units
    localparam logic [31:0] ANGLE_30 = 32'h1555_5555;
    localparam logic [31:0] ANGLE_60 = 32'h2AAA_AAAB;
    localparam logic [31:0] ANGLE_90 = 32'h4000_0000;

    localparam logic [1:0] MTYPE_SERVO   = 2'h0;
    localparam logic [1:0] MTYPE_SINE    = 2'h1;
    localparam logic [1:0] MTYPE_STEP_LO = 2'h2;
    localparam logic [1:0] MTYPE_STEP_HI = 2'h3;

    // smoothing in quarter units: 1 is 0.25, 256 is 64
    localparam logic [8:0] KS_MIN = 9'h001;
    localparam logic [8:0] KS_MAX = 9'h100;
    localparam logic [8:0] KS_RST = 9'h008;

    localparam logic [2:0]  HALL_BAD  = 3'h7;
    localparam logic [31:0] CYCLE_RST = 32'h0FA0_0000;

    typedef struct packed {
        logic [31:0] cycle;
        logic [31:0] hoff;
        logic [3:0]  hbase;
        logic        hall_en;
        logic [1:0]  mtype;
        logic [8:0]  ks;
    } cfg_s;

    localparam cfg_s CFG_RST = '{cycle: CYCLE_RST, hoff: 32'h0,
                                 hbase: 4'h0, hall_en: 1'b0,
                                 mtype: MTYPE_SERVO, ks: KS_RST};

    function automatic logic [2:0] hall_sector(input logic [2:0] c);
        case (c)
            3'h1:    return 3'h0;
            3'h3:    return 3'h1;
            3'h2:    return 3'h2;
            3'h6:    return 3'h3;
            3'h4:    return 3'h4;
            3'h5:    return 3'h5;
            default: return HALL_BAD;
        endcase
    endfunction : hall_sector

    function automatic logic [31:0] sector_angle(input logic [2:0] s);
        return 32'(s) * ANGLE_60;
    endfunction : sector_angle

    function automatic logic [8:0] ks_clamp(input logic [8:0] k);
        if (k < KS_MIN)
            return KS_MIN;
        if (k > KS_MAX)
            return KS_MAX;
        return k;
    endfunction : ks_clamp

    function automatic logic [15:0] abs16(input logic [15:0] v);
        return v[15] ? 16'(16'h0 - v) : v;
    endfunction : abs16

endpackage : commutation_pkg

// ===== logic/bit_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module bit_sync
    import commutation_pkg::*;
#(
    parameter int WIDTH = 1
)(
    input  wire logic             clk_sys_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] held;
    } sync_s;

    sync_s s_r;
    sync_s s_nxt;

    always_comb
    begin
        s_nxt.meta = d_i;
        s_nxt.held = s_r.meta;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign q_o = s_r.held;

endmodule : bit_sync

// ===== logic/commutation_and_step_output.sv
// commutation setup and step/direction output for one motor axis
// Operation
// - commutated axes each consume one command output
// - second phase goes to freed higher output
// - magnetic cycle length in counts sets period
// - self-test drives phases, reports wiring, cycle
// - self-test reports hall order and offset
// - burn writes configuration to non-volatile store
// - hall axes estimate phase after reset
// - zero init drives to zero, sets phase
// - positive ends off, negative holds, zero skipped
// - hall estimate within 30 degrees drives motor
// - counts to zero phase readable by host
// - armed calibration loads phase at hall edge
// - step pulses have fifty percent duty
// - stepper disables auxiliary encoder input
// - step count and encoder position separate
// - smoothing spans 0.25 to 64
// - stepper runs open loop, no servo
// - motor type selects step pulse polarity
`timescale 1ns/1ps
module commutation_and_step_output
    import commutation_pkg::*;
#(
    parameter int MS_CYC = MS_CYCLES
)(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        cfg_write_i,
    input  wire logic [31:0] magnetic_cycle_counts_i,
    input  wire logic [31:0] hall_offset_setting_i,
    input  wire logic [3:0]  hall_input_base_i,
    input  wire logic        hall_present_i,
    input  wire logic [1:0]  motor_type_setting_i,
    input  wire logic [8:0]  step_smoothing_i,
    input  wire logic [7:0]  commutate_sel_i,
    input  wire logic [3:0]  axis_count_i,
    input  wire logic        burn_config_i,
    input  wire logic [79:0] nv_data_i,
    input  wire logic        wiring_self_test_i,
    input  wire logic [15:0] self_test_volts_i,
    input  wire logic [15:0] self_test_ms_i,
    input  wire logic        zero_phase_init_i,
    input  wire logic [15:0] zero_init_volts_i,
    input  wire logic        hall_phase_calibrate_i,
    input  wire logic        motor_off_state_i,
    input  wire logic        servo_hold_state_i,
    input  wire logic        enc_a_i,
    input  wire logic        enc_b_i,
    input  wire logic [15:0] din_i,
    input  wire logic [15:0] vel_cmd_i,
    output logic      [3:0]  usable_axes_o,
    output logic      [23:0] phase2_map_o,
    output logic             nv_write_o,
    output logic      [79:0] nv_data_o,
    output logic      [31:0] comm_angle_o,
    output logic             phase_valid_o,
    output logic             force_drive_o,
    output logic      [15:0] phase_a_drive_o,
    output logic      [15:0] phase_b_drive_o,
    output logic             motor_enable_o,
    output logic             servo_loop_enable_o,
    output logic             busy_o,
    output logic             test_done_o,
    output logic             wiring_ok_o,
    output logic      [31:0] approx_cycle_o,
    output logic      [5:0]  hall_order_o,
    output logic      [31:0] hall_offset_report_o,
    output logic      [31:0] zero_phase_dist_o,
    output logic             step_pulse_out_o,
    output logic             direction_out_o,
    output logic      [31:0] step_count_query_o,
    output logic      [31:0] encoder_position_query_o,
    output logic             aux_encoder_enable_o
);
    typedef enum {ST_RESTORE, ST_IDLE, ST_TEST_A, ST_TEST_B, ST_ZERO} st_e;

    typedef struct packed {
        st_e          st;
        cfg_s         cfg;
        logic [23:0]  map;
        logic [3:0]   usable;
        logic [5:0]   div_cnt;
        logic [32:0]  rem;
        logic [31:0]  quo;
        logic [31:0]  inc;
        logic         ap;
        logic         bp;
        logic         up;
        logic [31:0]  enc;
        logic [31:0]  angle;
        logic         pvalid;
        logic [2:0]   hprev;
        logic         armed;
        logic         motor_on;
        logic [TICK_W-1:0] cyc;
        logic [15:0]  ms;
        logic [31:0]  pos0;
        logic [2:0]   hz;
        logic [2:0]   hq;
        logic         ok;
        logic [31:0]  approx;
        logic [31:0]  hrep;
        logic         done;
        logic         zneg;
        logic [15:0]  dra;
        logic [15:0]  drb;
        logic         force_on;
        logic [31:0]  zdist;
        logic [15:0]  vel;
        logic [8:0]   scnt;
        logic [16:0]  acc;
        logic         lvl;
        logic         dir;
        logic [31:0]  spos;
        logic         step_out;
        logic         aux_en;
        logic         loop_en;
        logic         nvw;
        cfg_s         nvd;
    } state_s;

    state_s       s_r;
    state_s       s_nxt;
    logic [1:0]   enc_s;
    logic [15:0]  din_s;
    logic [3:0]   nsel;
    logic [3:0]   k;
    logic [23:0]  map;
    logic         load;
    logic [32:0]  rem2;
    logic         cnt_en;
    logic         up;
    logic [2:0]   hall;
    logic [2:0]   sec;
    logic [31:0]  delta;
    logic [31:0]  zprod;
    logic         is_step;
    logic [15:0]  target;
    logic [16:0]  dif;
    logic [16:0]  sv;
    logic [16:0]  mag;
    logic         want;

    bit_sync #(.WIDTH(2)) u_enc_sync (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .d_i       ({enc_a_i, enc_b_i}),
        .q_o       (enc_s)
    );

    bit_sync #(.WIDTH(16)) u_din_sync (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .d_i       (din_i),
        .q_o       (din_s)
    );

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.nvw = 1'b0;
        s_nxt.done = 1'b0;
        load = 1'b0;
        nsel = 4'($countones(commutate_sel_i));
        k = 4'h0;
        map = 24'h0;
        for (int i = 0; i < NUM_OUT; i++)
        begin
            if (commutate_sel_i[i])
            begin
                map[i*3 +: 3] = 3'(axis_count_i - nsel + k);
                k = 4'(k + 4'h1);
            end
        end
        s_nxt.map = map;
        s_nxt.usable = 4'(axis_count_i - nsel);
        if (s_r.st == ST_RESTORE)
        begin
            s_nxt.cfg = cfg_s'(nv_data_i);
            s_nxt.cfg.ks = ks_clamp(s_nxt.cfg.ks);
            s_nxt.st = ST_IDLE;
            load = 1'b1;
        end
        else if (cfg_write_i && s_r.st == ST_IDLE)
        begin
            s_nxt.cfg = '{magnetic_cycle_counts_i, hall_offset_setting_i,
                          hall_input_base_i, hall_present_i,
                          motor_type_setting_i, ks_clamp(step_smoothing_i)};
            load = 1'b1;
        end
        // angle per count is 2^48 over the q16 cycle
        rem2 = {s_r.rem[31:0], 1'b0};
        if (load)
        begin
            s_nxt.div_cnt = 6'(DIV_STEPS);
            s_nxt.rem = 33'h1;
            s_nxt.quo = 32'h0;
        end
        else if (s_r.div_cnt != 6'h0)
        begin
            s_nxt.quo = {s_r.quo[30:0], rem2 >= {1'b0, s_r.cfg.cycle}};
            s_nxt.rem = s_nxt.quo[0] ? 33'(rem2 - {1'b0, s_r.cfg.cycle})
                                     : rem2;
            s_nxt.div_cnt = 6'(s_r.div_cnt - 6'h1);
            if (s_r.div_cnt == 6'h1)
                s_nxt.inc = (s_r.cfg.cycle[31:16] == 16'h0) ? 32'h0
                                                              : s_nxt.quo;
        end
        // quadrature decode keeps encoder and angle in step
        cnt_en = enc_s[1] ^ s_r.ap ^ enc_s[0] ^ s_r.bp;
        up = enc_s[1] ^ s_r.bp;
        s_nxt.ap = enc_s[1];
        s_nxt.bp = enc_s[0];
        if (cnt_en)
        begin
            s_nxt.up = up;
            s_nxt.enc = up ? s_r.enc + 32'h1 : s_r.enc - 32'h1;
            s_nxt.angle = up ? s_r.angle + s_r.inc : s_r.angle - s_r.inc;
        end
        // hall lines start at the base input
        hall = 3'(din_s >> s_r.cfg.hbase);
        sec = hall_sector(hall);
        s_nxt.hprev = hall;
        if (s_r.cfg.hall_en && s_r.cfg.mtype == MTYPE_SINE && !s_r.pvalid
            && sec != HALL_BAD && s_r.st == ST_IDLE)
        begin
            s_nxt.angle = sector_angle(sec) + ANGLE_30 + s_r.cfg.hoff;
            s_nxt.pvalid = 1'b1;
        end
        // exact edge at the first transition
        if (s_r.armed && hall != s_r.hprev && sec != HALL_BAD)
        begin
            s_nxt.angle = (s_r.up ? sector_angle(sec)
                          : sector_angle(3'(sec + 3'h1))) + s_r.cfg.hoff;
            s_nxt.pvalid = 1'b1;
            s_nxt.armed = 1'b0;
        end
        if (hall_phase_calibrate_i && s_r.cfg.hall_en)
            s_nxt.armed = 1'b1;
        if (motor_off_state_i)
            s_nxt.motor_on = 1'b0;
        else if (servo_hold_state_i
                 && (s_r.pvalid || s_r.cfg.mtype != MTYPE_SINE))
            s_nxt.motor_on = 1'b1;
        // millisecond timebase runs only while a sequence is busy
        if (s_r.st != ST_IDLE && s_r.st != ST_RESTORE)
        begin
            s_nxt.cyc = TICK_W'(s_r.cyc + 1'b1);
            if (s_r.cyc == TICK_W'(MS_CYC - 1))
            begin
                s_nxt.cyc = '0;
                s_nxt.ms = 16'(s_r.ms + 16'h1);
            end
        end
        delta = s_r.enc - s_r.pos0;
        unique case (s_r.st)
            ST_RESTORE:
                s_nxt.st = ST_IDLE;
            ST_IDLE:
            begin
                s_nxt.cyc = '0;
                s_nxt.ms = 16'h0;
                // phase a first, then phase b
                if (wiring_self_test_i && s_r.cfg.mtype == MTYPE_SINE)
                begin
                    s_nxt.st = ST_TEST_A;
                    s_nxt.force_on = 1'b1;
                    s_nxt.dra = self_test_volts_i;
                    s_nxt.drb = 16'h0;
                    s_nxt.motor_on = 1'b0;
                end
                // zero volts means the axis is left alone
                else if (zero_phase_init_i && zero_init_volts_i != 16'h0)
                begin
                    s_nxt.st = ST_ZERO;
                    s_nxt.zneg = zero_init_volts_i[15];
                    s_nxt.force_on = 1'b1;
                    s_nxt.dra = abs16(zero_init_volts_i);
                    s_nxt.drb = 16'h0;
                    s_nxt.motor_on = 1'b0;
                end
            end
            ST_TEST_A:
                if (s_r.ms == self_test_ms_i)
                begin
                    s_nxt.st = ST_TEST_B;
                    s_nxt.pos0 = s_r.enc;
                    s_nxt.hz = hall;
                    s_nxt.dra = 16'h0;
                    s_nxt.drb = self_test_volts_i;
                    s_nxt.cyc = '0;
                    s_nxt.ms = 16'h0;
                end
            ST_TEST_B:
                // any forward movement means good wiring, taken as a quarter turn
                if (s_r.ms == self_test_ms_i)
                begin
                    s_nxt.st = ST_IDLE;
                    s_nxt.ok = !delta[31] && delta != 32'h0;
                    s_nxt.approx = 32'((delta[31] ? 32'h0 - delta
                                                  : delta) << 2);
                    s_nxt.hq = hall;
                    s_nxt.hrep = 32'h0 - sector_angle(hall_sector(s_r.hz));
                    s_nxt.angle = ANGLE_90;
                    s_nxt.pvalid = !delta[31] && delta != 32'h0;
                    s_nxt.force_on = 1'b0;
                    s_nxt.drb = 16'h0;
                    s_nxt.done = 1'b1;
                end
            ST_ZERO:
                // rotor parked at zero, phase cleared
                if (s_r.ms == 16'(ZERO_SETTLE_MS))
                begin
                    s_nxt.st = ST_IDLE;
                    s_nxt.angle = 32'h0;
                    s_nxt.pvalid = 1'b1;
                    s_nxt.force_on = 1'b0;
                    s_nxt.dra = 16'h0;
                    s_nxt.motor_on = s_r.zneg;
                end
        endcase
        // fraction of a cycle times cycle length
        zprod = s_r.angle[31:16] * s_r.cfg.cycle[31:16];
        s_nxt.zdist = {16'h0, zprod[31:16]};
        // snapshot taken at the burn request
        if (burn_config_i)
        begin
            s_nxt.nvw = 1'b1;
            s_nxt.nvd = s_r.cfg;
        end
        is_step = s_r.cfg.mtype[1];
        target = s_r.motor_on ? vel_cmd_i : 16'h0;
        dif = 17'({target[15], target} - {s_r.vel[15], s_r.vel});
        sv = 17'($signed(dif) >>> 2);
        if (sv == 17'h0 && dif != 17'h0)
            sv = dif[16] ? 17'h1FFFF : 17'h1;
        mag = s_r.vel[15] ? 17'(17'h0 - {1'b1, s_r.vel})
                          : {1'b0, s_r.vel};
        want = !s_r.vel[15];
        if (!is_step)
        begin
            s_nxt.vel = 16'h0;
            s_nxt.scnt = 9'h0;
            s_nxt.acc = 17'h0;
            s_nxt.lvl = 1'b0;
        end
        else
        begin
            // longer update spacing gives heavier smoothing
            if (9'(s_r.scnt + 9'h1) >= s_r.cfg.ks)
            begin
                s_nxt.scnt = 9'h0;
                s_nxt.vel = 16'(s_r.vel + sv[15:0]);
            end
            else
                s_nxt.scnt = 9'(s_r.scnt + 9'h1);
            // turn direction only while the pulse is idle
            if (want != s_r.dir && !s_r.lvl && mag != 17'h0)
                s_nxt.dir = want;
            else
            begin
                // carry toggles level, one step per two carries
                s_nxt.acc = 17'({1'b0, s_r.acc[15:0]} + mag);
                if (s_nxt.acc[16])
                begin
                    s_nxt.lvl = !s_r.lvl;
                    // count taken on the active edge
                    if (!s_r.lvl)
                        s_nxt.spos = s_r.dir ? s_r.spos + 32'h1
                                             : s_r.spos - 32'h1;
                end
            end
            // a stopped axis parks its line idle, cutting the last pulse
            if (mag == 17'h0)
                s_nxt.lvl = 1'b0;
        end
        s_nxt.step_out = s_nxt.lvl ^ (s_nxt.cfg.mtype == MTYPE_STEP_LO);
        // steppers need no aux input and no loop
        s_nxt.aux_en = !s_nxt.cfg.mtype[1];
        s_nxt.loop_en = s_nxt.motor_on && !s_nxt.cfg.mtype[1];
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_r <= '0;
            s_r.st <= ST_RESTORE;
            s_r.cfg <= CFG_RST;
            s_r.nvd <= CFG_RST;
            s_r.dir <= 1'b1;
            s_r.aux_en <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    assign usable_axes_o = s_r.usable;
    assign phase2_map_o = s_r.map;
    assign nv_write_o = s_r.nvw;
    assign nv_data_o = s_r.nvd;
    assign comm_angle_o = s_r.angle;
    assign phase_valid_o = s_r.pvalid;
    assign force_drive_o = s_r.force_on;
    assign phase_a_drive_o = s_r.dra;
    assign phase_b_drive_o = s_r.drb;
    assign motor_enable_o = s_r.motor_on;
    assign servo_loop_enable_o = s_r.loop_en;
    assign busy_o = s_r.force_on;
    assign test_done_o = s_r.done;
    assign wiring_ok_o = s_r.ok;
    assign approx_cycle_o = s_r.approx;
    assign hall_order_o = {s_r.hq, s_r.hz};
    assign hall_offset_report_o = s_r.hrep;
    assign zero_phase_dist_o = s_r.zdist;
    assign step_pulse_out_o = s_r.step_out;
    assign direction_out_o = s_r.dir;
    assign step_count_query_o = s_r.spos;
    assign encoder_position_query_o = s_r.enc;
    assign aux_encoder_enable_o = s_r.aux_en;

    AST_USABLE:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_r.st == ST_IDLE && $stable(commutate_sel_i)
        && $stable(axis_count_i) |=>
        usable_axes_o == 4'(axis_count_i - $countones(commutate_sel_i)))
    else $error("usable axis count wrong");
    AST_DIR_SETTLED:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $changed(s_r.dir) |-> !s_r.lvl && !$past(s_r.lvl))
    else $error("step issued with direction change");
    AST_BURN:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        burn_config_i |=> nv_write_o && nv_data_o == $past(s_r.cfg))
    else $error("burn did not write configuration");
    AST_ZERO_END:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_r.st == ST_ZERO && s_nxt.st == ST_IDLE |=>
        comm_angle_o == 32'h0 && phase_valid_o && !force_drive_o)
    else $error("zero init did not clear phase");
    AST_ZERO_STATE:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_r.st == ST_ZERO && s_nxt.st == ST_IDLE && !motor_off_state_i
        |=> motor_enable_o == $past(s_r.zneg))
    else $error("zero init end state wrong");
    AST_ZERO_SKIP:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_r.st == ST_IDLE && zero_phase_init_i && zero_init_volts_i == 16'h0
        && !wiring_self_test_i |=> !force_drive_o [*2])
    else $error("axis driven with zero volts");
    AST_STEP_LOOP:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_r.cfg.mtype[1] |-> !servo_loop_enable_o && !aux_encoder_enable_o)
    else $error("stepper left loop or aux input on");
    AST_STEP_COUNT:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(s_r.lvl) |-> s_r.spos ==
        ($past(s_r.dir) ? $past(s_r.spos) + 32'h1 : $past(s_r.spos) - 32'h1))
    else $error("step count missed an edge");
    AST_POLARITY:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(s_r.lvl) && s_r.cfg.mtype == MTYPE_STEP_LO
        && $stable(s_r.cfg.mtype) |-> $fell(step_pulse_out_o))
    else $error("active low step not low");
    AST_SMOOTH_RANGE:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_r.st != ST_RESTORE |-> s_r.cfg.ks inside {[KS_MIN:KS_MAX]})
    else $error("smoothing out of range");
    AST_NO_PHASE_OFF:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_r.cfg.mtype == MTYPE_SINE && !phase_valid_o && !motor_enable_o
        && s_r.st == ST_IDLE |=> !motor_enable_o)
    else $error("motor enabled without phase");
    AST_CALIB:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_r.armed && hall != s_r.hprev && sec != HALL_BAD
        && !hall_phase_calibrate_i |=> !s_r.armed && phase_valid_o)
    else $error("calibration did not load phase");

endmodule : commutation_and_step_output

// ===== tb/amp_model.sv
// amplifier and motor stand-in: forced drive turns the rotor
`timescale 1ns/1ps
module amp_model (
    input  wire logic        clk_sys_i,
    input  wire logic [15:0] phase_a_i,
    input  wire logic [15:0] phase_b_i,
    output logic             enc_a_o,
    output logic             enc_b_o,
    output logic      [15:0] din_o
);
    logic [7:0] pos_r = 8'h00;
    // rotor creeps one count a clock while any phase is driven
    always @(posedge clk_sys_i)
        if (phase_a_i != 16'h0000 || phase_b_i != 16'h0000)
            pos_r <= pos_r + 8'h01;
    // a leads b while the rotor turns forward
    assign enc_a_o = pos_r[1] ^ pos_r[0];
    assign enc_b_o = pos_r[1];
    assign din_o = {13'h0000, pos_r[5] ? 3'h3 : 3'h1};
endmodule : amp_model

// ===== tb/commutation_and_step_output_test.sv
// self-checking bench for the axis commutation and step block
`timescale 1ns/1ps
module commutation_and_step_output_test
    import commutation_pkg::*;
();
    logic clk_sys_i, rst_n_i, cfg_write_i, hall_present_i, burn_config_i;
    logic wiring_self_test_i, zero_phase_init_i, hall_phase_calibrate_i;
    logic motor_off_state_i, servo_hold_state_i, enc_a_i, enc_b_i;
    logic [31:0] magnetic_cycle_counts_i, hall_offset_setting_i;
    logic [3:0] hall_input_base_i, axis_count_i, usable_axes_o;
    logic [1:0] motor_type_setting_i;
    logic [8:0] step_smoothing_i;
    logic [7:0] commutate_sel_i;
    logic [79:0] nv_data_i, nv_data_o;
    logic [15:0] self_test_volts_i, self_test_ms_i, zero_init_volts_i;
    logic [15:0] din_i, vel_cmd_i, phase_a_drive_o, phase_b_drive_o;
    logic [23:0] phase2_map_o;
    logic [5:0] hall_order_o;
    logic nv_write_o, phase_valid_o, force_drive_o, motor_enable_o, busy_o;
    logic servo_loop_enable_o, test_done_o, wiring_ok_o, step_pulse_out_o;
    logic direction_out_o, aux_encoder_enable_o;
    logic [31:0] comm_angle_o, approx_cycle_o, hall_offset_report_o;
    logic [31:0] zero_phase_dist_o, step_count_query_o;
    logic [31:0] encoder_position_query_o, sc, ep;
    cfg_s nv_cfg;
    int mismatches = 0, n_compared = 0, k;

    commutation_and_step_output #(.MS_CYC(10)) u_dut (.*);
    amp_model u_amp (.clk_sys_i(clk_sys_i), .phase_a_i(phase_a_drive_o),
        .phase_b_i(phase_b_drive_o), .enc_a_o(enc_a_i), .enc_b_o(enc_b_i),
        .din_o(din_i));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input logic [95:0] s, input logic [95:0] e);
        n_compared++;
        if (s !== e)
        begin
            mismatches++;
            $display("ERROR %0t seen %h exp %h", $time, s, e);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : tick

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done

    task automatic zinit(input logic [15:0] v, input logic en);
        tick(1);
        zero_init_volts_i <= v;
        zero_phase_init_i <= 1'b1;
        tick(1);
        zero_phase_init_i <= 1'b0;
        #1;
        if (v == 16'h0000)
            chk(busy_o, 1'b0);
        else
        begin
            chk(phase_a_drive_o, v[15] ? 16'(16'h0000 - v) : v);
            for (k = 0; k < 6000 && busy_o !== 1'b0; k++)
                @(negedge clk_sys_i);
            chk({comm_angle_o, phase_valid_o}, 33'h1);
            chk(motor_enable_o, en);
        end
    endtask : zinit

    task automatic stp(input logic [1:0] t, input logic act);
        tick(1);
        motor_type_setting_i <= t;
        cfg_write_i <= 1'b1;
        tick(1);
        cfg_write_i <= 1'b0;
        servo_hold_state_i <= 1'b1;
        tick(1);
        servo_hold_state_i <= 1'b0;
        tick(3);
        chk(step_pulse_out_o, !act);
        vel_cmd_i <= 16'h4000;
        tick(2000);
        @(negedge clk_sys_i);
        sc = step_count_query_o;
        ep = encoder_position_query_o;
        k = 0;
        repeat (800) @(negedge clk_sys_i) k += (step_pulse_out_o === act);
        chk(k, 400);
        chk(32'(step_count_query_o - sc), 100);
        chk(encoder_position_query_o, ep);
        chk({aux_encoder_enable_o, servo_loop_enable_o}, 2'h0);
        chk(direction_out_o, 1'b1);
        vel_cmd_i <= 16'hC000;
        tick(2000);
        chk(direction_out_o, 1'b0);
        vel_cmd_i <= 16'h0000;
        motor_off_state_i <= 1'b1;
        tick(1);
        motor_off_state_i <= 1'b0;
        tick(300);
    endtask : stp

    initial
    begin
        nv_cfg = '{cycle: 32'hF230_0000, hoff: 32'h0, hbase: 4'h0,
                   hall_en: 1'b1, mtype: MTYPE_SINE, ks: KS_RST};
        {rst_n_i, cfg_write_i, hall_present_i, burn_config_i} = 4'h0;
        {wiring_self_test_i, zero_phase_init_i} = 2'h0;
        {hall_phase_calibrate_i, motor_off_state_i, servo_hold_state_i} = 3'h0;
        nv_data_i = nv_cfg;
        magnetic_cycle_counts_i = nv_cfg.cycle;
        {hall_offset_setting_i, hall_input_base_i} = 36'h0;
        {motor_type_setting_i, step_smoothing_i} = {MTYPE_SINE, KS_MIN};
        {commutate_sel_i, axis_count_i} = {8'h05, 4'h7};
        {self_test_volts_i, self_test_ms_i} = {16'h0200, 16'h0001};
        {zero_init_volts_i, vel_cmd_i} = 32'h0;
        tick(6);
        rst_n_i <= 1'b1;
        tick(60);
        chk(usable_axes_o, 4'h5);
        chk(phase2_map_o, 24'h000185);
        chk({comm_angle_o, phase_valid_o}, {ANGLE_30, 1'b1});
        motor_off_state_i <= 1'b1;
        tick(1);
        motor_off_state_i <= 1'b0;
        burn_config_i <= 1'b1;
        tick(1);
        burn_config_i <= 1'b0;
        #1;
        chk({nv_write_o, nv_data_o}, {1'b1, nv_cfg});
        tick(1);
        wiring_self_test_i <= 1'b1;
        tick(1);
        wiring_self_test_i <= 1'b0;
        #1;
        chk({force_drive_o, phase_a_drive_o}, {1'b1, 16'h0200});
        for (k = 0; k < 40 && test_done_o !== 1'b1; k++)
            @(negedge clk_sys_i);
        chk(comm_angle_o, ANGLE_90);
        chk({hall_order_o, hall_offset_report_o, wiring_ok_o,
             approx_cycle_o}, {6'h09, 32'h0, 1'b1, 32'h2C});
        @(negedge clk_sys_i);
        chk(zero_phase_dist_o, 32'h3C8C);
        tick(2);
        hall_phase_calibrate_i <= 1'b1;
        tick(1);
        hall_phase_calibrate_i <= 1'b0;
        zinit(16'h0200, 1'b0);
        zinit(16'hFE00, 1'b1);
        zinit(16'h0000, 1'b1);
        stp(MTYPE_STEP_LO, 1'b0);
        stp(MTYPE_STEP_HI, 1'b1);
        test_done;
    end

    initial
    begin
        tick(30000);
        mismatches++;
        test_done;
    end
endmodule : commutation_and_step_output_test
